/* rtl/lbr_pkg.sv */
/*
 * Shared constants and types of the local-bus strap, reset and interrupt
 * block. Assumes one 40 MHz clock and a simple word register port.
 */
`default_nettype none

package lbr_pkg;

    // Clocking
    localparam int CLK_HZ = 40_000_000;
    localparam int LOCAL_CLK_MAX_HZ = 50_000_000;

    // Register port
    localparam int REG_AW = 8;
    localparam logic [REG_AW-1:0] REG_CONFIG = 8'h00;
    localparam logic [REG_AW-1:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [REG_AW-1:0] REG_IRQ_CLEAR = 8'h08;
    localparam logic [REG_AW-1:0] REG_IRQ_ENABLE = 8'h0c;
    localparam logic [REG_AW-1:0] REG_CFG_ADDR = 8'h10;
    localparam logic [REG_AW-1:0] REG_CFG_DATA = 8'h14;

    // Configuration register fields
    localparam int CFG_INIT_BIT = 0;
    localparam int CFG_ROOT_BIT = 1;
    localparam int CFG_WIDE_BIT = 2;
    localparam int CFG_LONG_BIT = 3;
    localparam int CFG_BUSY_BIT = 4;

    // Interrupt causes
    localparam int N_IRQ = 3;
    localparam int IRQ_CFG_DONE = 0;
    localparam int IRQ_MISALIGN = 1;
    localparam int IRQ_EXT = 2;

    // Burst lengths and lane masks
    localparam logic [3:0] BEATS_LONG = 4'h8;
    localparam logic [3:0] BEATS_SHORT = 4'h4;
    localparam logic [3:0] BEATS_SINGLE = 4'h1;
    localparam logic [7:0] LANES_WIDE = 8'hff;
    localparam logic [7:0] LANES_NARROW = 8'hf0;

    // Reset output hold after last source goes away
    localparam int RELEASE_CYCLES = 4;

    typedef struct packed {
        logic req;
        logic [31:2] addr;
    } burst_req_t;

    typedef struct packed {
        logic req;
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
    } cfg_cycle_t;

    typedef struct packed {
        logic root;
        logic wide;
        logic longBurst;
    } straps_t;

    typedef enum logic [1:0] {
        CFG_IDLE = 2'b00,
        CFG_BUSY = 2'b01
    } cfg_state_t;

endpackage

`default_nettype wire

/* rtl/reset_release.sv */
/*
 * Local reset output stage: asserts at once on request, releases after a
 * fixed count of idle cycles. Assumes the request is synchronous.
 */
`default_nettype none

module reset_release #(
    parameter int HOLD = lbr_pkg::RELEASE_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Reset request and output
    input wire logic assertReq,
    output logic rstOut_n
);

    if (HOLD < 2 || HOLD > 255) begin : g_bad_hold
        $error("HOLD must lie in 2..255");
    end

    typedef struct packed {
        logic out_n;
        logic [7:0] cnt;
    } rel_t;

    rel_t s;
    rel_t next_s;

    always_comb begin
        next_s = s;
        if (assertReq) begin
            next_s.out_n = 1'b0;
            next_s.cnt = 8'h00;
        end else if (!s.out_n) begin
            if (s.cnt == 8'(HOLD - 1)) begin
                next_s.out_n = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rstOut_n = s.out_n;

    property p_release_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(rstOut_n) |-> !$past(assertReq) && !$past(assertReq, 2);
    endproperty
    a_release_quiet: assert property (p_release_quiet)
        else $error("Reset output released too soon");

endmodule // reset_release

`default_nettype wire

/* rtl/local_bus_strap_reset_irq.sv */
/*
 * Local-bus control of the bridge: straps, reset output, register clearing,
 * configuration cycle launch, burst acknowledge and local interrupt.
 * Assumes all pins synchronous to ref_clk and a simple register port.
 */
// Behaviour
// - Local side runs on one clock, max 50MHz
// - Local reset in clears init-complete bit
// - Local reset in clears all non-PCI registers
// - Local reset in asserts local reset out
// - PCI reset asserts local reset out
// - Software reset bit asserts local reset out
// - Root strap high enables configuration cycles
// - Root strap low ignores configuration registers
// - Width strap high uses all eight lanes
// - Width strap low uses lanes four-seven only
// - Burst strap high gives eight-beat bursts
// - Burst strap low gives four-beat bursts
// - Enabled pending cause drives interrupt low
// - Misaligned burst gets single transfer, no acknowledge
`default_nettype none

module local_bus_strap_reset_irq (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [lbr_pkg::REG_AW-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Reset sources and output
    input wire logic local_reset_in_n,
    input wire logic pci_side_reset_n,
    input wire logic pciRstRegWrite,
    input wire logic pciRstRegData,
    output logic local_reset_out_n,
    // Straps
    input wire logic rootBridgeStrap,
    input wire logic local_width_strap,
    input wire logic burst_length_strap,
    // Burst requests
    input wire lbr_pkg::burst_req_t burstIn,
    output logic burst_acknowledge_n,
    output logic [3:0] transferBeats,
    output logic [7:0] laneValid,
    // Configuration cycles
    output lbr_pkg::cfg_cycle_t cfgCycle,
    input wire logic cfgDone,
    input wire logic [31:0] cfgRdata,
    // Interrupt
    input wire logic extCause,
    output logic localIrq_n
);

    // Local side must not exceed its rated clock
    if (lbr_pkg::CLK_HZ > lbr_pkg::LOCAL_CLK_MAX_HZ) begin : g_bad_clk
        $error("Clock above local bus limit");
    end

    typedef struct packed {
        logic [31:0] rdata;
        logic initDone;
        lbr_pkg::straps_t straps;
        logic strapsTaken;
        logic [lbr_pkg::N_IRQ-1:0] status;
        logic [lbr_pkg::N_IRQ-1:0] enable;
        logic [31:0] cfgAddr;
        logic [31:0] cfgData;
        lbr_pkg::cfg_state_t cfgState;
        lbr_pkg::cfg_cycle_t cfgOut;
        logic burst_acknowledge_n_n;
        logic [3:0] beats;
        logic [7:0] lanes;
        logic irq_n;
        logic softReset;
    } st_t;

    st_t s;
    st_t next_s;
    logic resetReq;

    function automatic logic burstAligned(input logic [31:2] a,
                                          input logic wide,
                                          input logic longBurst);
        logic [3:0] low;
        low = wide ? a[6:3] : a[5:2];
        burstAligned = longBurst ? (low[2:0] == 3'h0) : (low[1:0] == 2'h0);
    endfunction

    always_comb begin
        logic [lbr_pkg::N_IRQ-1:0] ev;
        logic [lbr_pkg::N_IRQ-1:0] clr;
        ev = '0;
        clr = '0;
        next_s = s;
        next_s.rdata = 32'h0000_0000;
        next_s.burst_acknowledge_n_n = 1'b1;
        next_s.cfgOut.req = 1'b0;

        // Straps caught after reset and while local reset is held
        if (!local_reset_in_n || !s.strapsTaken) begin
            next_s.straps.root = rootBridgeStrap;
            next_s.straps.wide = local_width_strap;
            next_s.straps.longBurst = burst_length_strap;
            next_s.strapsTaken = 1'b1;
        end

        unique case (s.cfgState)
            lbr_pkg::CFG_IDLE: ;
            lbr_pkg::CFG_BUSY: begin
                if (cfgDone) begin
                    ev[lbr_pkg::IRQ_CFG_DONE] = 1'b1;
                    if (!s.cfgOut.write) begin
                        next_s.cfgData = cfgRdata;
                    end
                    next_s.cfgState = lbr_pkg::CFG_IDLE;
                end
            end
            default: next_s.cfgState = lbr_pkg::CFG_IDLE;
        endcase

        if (regWr) begin
            case (regAddr)
                lbr_pkg::REG_CONFIG:
                    next_s.initDone = regWdata[lbr_pkg::CFG_INIT_BIT];
                lbr_pkg::REG_IRQ_CLEAR:
                    clr = regWdata[lbr_pkg::N_IRQ-1:0];
                lbr_pkg::REG_IRQ_ENABLE:
                    next_s.enable = regWdata[lbr_pkg::N_IRQ-1:0];
                lbr_pkg::REG_CFG_ADDR: begin
                    // Address write launches a configuration read
                    if (s.straps.root && s.cfgState == lbr_pkg::CFG_IDLE)
                    begin
                        next_s.cfgAddr = regWdata;
                        next_s.cfgOut = '{1'b1, 1'b0, regWdata, s.cfgData};
                        next_s.cfgState = lbr_pkg::CFG_BUSY;
                    end
                end
                lbr_pkg::REG_CFG_DATA: begin
                    if (s.straps.root && s.cfgState == lbr_pkg::CFG_IDLE)
                    begin
                        next_s.cfgData = regWdata;
                        next_s.cfgOut = '{1'b1, 1'b1, s.cfgAddr, regWdata};
                        next_s.cfgState = lbr_pkg::CFG_BUSY;
                    end
                end
                default: ;
            endcase
        end

        if (regRd) begin
            case (regAddr)
                lbr_pkg::REG_CONFIG: begin
                    next_s.rdata[lbr_pkg::CFG_INIT_BIT] = s.initDone;
                    next_s.rdata[lbr_pkg::CFG_ROOT_BIT] = s.straps.root;
                    next_s.rdata[lbr_pkg::CFG_WIDE_BIT] = s.straps.wide;
                    next_s.rdata[lbr_pkg::CFG_LONG_BIT] = s.straps.longBurst;
                    next_s.rdata[lbr_pkg::CFG_BUSY_BIT] =
                        (s.cfgState == lbr_pkg::CFG_BUSY);
                end
                lbr_pkg::REG_IRQ_STATUS:
                    next_s.rdata[lbr_pkg::N_IRQ-1:0] = s.status;
                lbr_pkg::REG_IRQ_ENABLE:
                    next_s.rdata[lbr_pkg::N_IRQ-1:0] = s.enable;
                lbr_pkg::REG_CFG_ADDR:
                    if (s.straps.root) next_s.rdata = s.cfgAddr;
                lbr_pkg::REG_CFG_DATA:
                    if (s.straps.root) next_s.rdata = s.cfgData;
                default: ;
            endcase
        end

        // Burst acknowledge only for aligned requests
        if (burstIn.req) begin
            if (burstAligned(burstIn.addr, s.straps.wide,
                             s.straps.longBurst)) begin
                next_s.burst_acknowledge_n_n = 1'b0;
                next_s.beats = s.straps.longBurst ? lbr_pkg::BEATS_LONG
                                                  : lbr_pkg::BEATS_SHORT;
            end else begin
                next_s.beats = lbr_pkg::BEATS_SINGLE;
                ev[lbr_pkg::IRQ_MISALIGN] = 1'b1;
            end
        end
        next_s.lanes = s.straps.wide ? lbr_pkg::LANES_WIDE
                                     : lbr_pkg::LANES_NARROW;

        ev[lbr_pkg::IRQ_EXT] = extCause;
        for (int i = 0; i < lbr_pkg::N_IRQ; i++) begin
            // New event wins over a clear in the same cycle
            next_s.status[i] = ev[i] | (s.status[i] & ~clr[i]);
        end

        // Registers of the PCI configuration space survive local reset
        if (!pci_side_reset_n) begin
            next_s.softReset = 1'b0;
        end else if (pciRstRegWrite) begin
            next_s.softReset = pciRstRegData;
        end

        if (!local_reset_in_n) begin
            next_s.initDone = 1'b0;
            next_s.status = '0;
            next_s.enable = '0;
            next_s.cfgAddr = 32'h0000_0000;
            next_s.cfgData = 32'h0000_0000;
            next_s.cfgState = lbr_pkg::CFG_IDLE;
            next_s.cfgOut = '0;
        end

        next_s.irq_n = ~|(next_s.status & next_s.enable);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.burst_acknowledge_n_n <= 1'b1;
            s.irq_n <= 1'b1;
            s.lanes <= lbr_pkg::LANES_NARROW;
            s.beats <= lbr_pkg::BEATS_SINGLE;
        end else begin
            s <= next_s;
        end
    end

    assign resetReq = !local_reset_in_n || !pci_side_reset_n
                      || s.softReset;

    reset_release #(
        .HOLD(lbr_pkg::RELEASE_CYCLES)
    ) u_release (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .assertReq(resetReq),
        .rstOut_n(local_reset_out_n)
    );

    assign regRdata = s.rdata;
    assign burst_acknowledge_n = s.burst_acknowledge_n_n;
    assign transferBeats = s.beats;
    assign laneValid = s.lanes;
    assign cfgCycle = s.cfgOut;
    assign localIrq_n = s.irq_n;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_init_clear;
        !local_reset_in_n |=> !s.initDone;
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("Init bit not cleared by local reset");
    property p_regs_clear;
        !local_reset_in_n |=> s.status == '0 && s.enable == '0
            && s.cfgAddr == 32'h0000_0000 && localIrq_n;
    endproperty
    a_regs_clear: assert property (p_regs_clear)
        else $error("Registers not cleared by local reset");
    property p_rst_local;
        !local_reset_in_n |=> !local_reset_out_n;
    endproperty
    a_rst_local: assert property (p_rst_local)
        else $error("Local reset in did not assert reset out");
    property p_rst_pci;
        !pci_side_reset_n |=> !local_reset_out_n;
    endproperty
    a_rst_pci: assert property (p_rst_pci)
        else $error("PCI reset did not assert reset out");
    property p_rst_soft;
        pci_side_reset_n && pciRstRegWrite && pciRstRegData
            |=> ##1 !local_reset_out_n;
    endproperty
    a_rst_soft: assert property (p_rst_soft)
        else $error("Software reset did not assert reset out");
    property p_cfg_launch;
        regWr && regAddr == lbr_pkg::REG_CFG_DATA && s.straps.root
            && s.cfgState == lbr_pkg::CFG_IDLE && local_reset_in_n
            |=> cfgCycle.req && cfgCycle.write
                && cfgCycle.data == $past(regWdata);
    endproperty
    a_cfg_launch: assert property (p_cfg_launch)
        else $error("Configuration write not launched");
    property p_cfg_blocked;
        !s.straps.root && local_reset_in_n |=> !cfgCycle.req
            && $stable(s.cfgAddr);
    endproperty
    a_cfg_blocked: assert property (p_cfg_blocked)
        else $error("Configuration cycle without root strap");
    property p_lanes;
        s.straps.wide |=> laneValid == lbr_pkg::LANES_WIDE;
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("Wide strap lane mask wrong");
    property p_burst_ack;
        burstIn.req && burstAligned(burstIn.addr, s.straps.wide,
                                    s.straps.longBurst)
            |=> !burst_acknowledge_n && transferBeats ==
                ($past(s.straps.longBurst) ? lbr_pkg::BEATS_LONG
                                           : lbr_pkg::BEATS_SHORT);
    endproperty
    a_burst_ack: assert property (p_burst_ack)
        else $error("Aligned burst length or acknowledge wrong");
    property p_misalign;
        burstIn.req && !burstAligned(burstIn.addr, s.straps.wide,
                                     s.straps.longBurst) && local_reset_in_n
            |=> burst_acknowledge_n && transferBeats == lbr_pkg::BEATS_SINGLE
                && s.status[lbr_pkg::IRQ_MISALIGN];
    endproperty
    a_misalign: assert property (p_misalign)
        else $error("Misaligned burst was acknowledged");
    property p_irq_level;
        localIrq_n == !(|(s.status & s.enable));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt output disagrees with pending causes");
    property p_irq_hold;
        !localIrq_n && local_reset_in_n && !(regWr
            && (regAddr == lbr_pkg::REG_IRQ_CLEAR
                || regAddr == lbr_pkg::REG_IRQ_ENABLE)) |=> !localIrq_n;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("Interrupt released without software action");

    c_burst: cover property (!burst_acknowledge_n);
    c_misalign: cover property (transferBeats == lbr_pkg::BEATS_SINGLE
                                && s.status[lbr_pkg::IRQ_MISALIGN]);
    c_cfg_done: cover property (s.cfgState == lbr_pkg::CFG_BUSY && cfgDone);
    c_irq: cover property ($fell(localIrq_n));

endmodule // local_bus_strap_reset_irq

`default_nettype wire

/* verif/cfg_responder.sv */
/*
 * Far-side model that answers configuration cycles, promptly or slowly.
 * Assumes requests arrive as one-cycle pulses on the block's clock.
 */
`default_nettype none

module cfg_responder (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Configuration cycle side
    input wire lbr_pkg::cfg_cycle_t cfgCycle,
    input wire logic slow,
    output logic cfgDone,
    output logic [31:0] cfgRdata
);
    timeunit 1ns;
    timeprecision 100ps;
    int waitN;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            waitN <= 0;
            cfgDone <= 1'b0;
            cfgRdata <= 32'h0;
        end else begin
            cfgDone <= 1'b0;
            // Data not valid outside the done cycle: keep it moving
            cfgRdata <= ~cfgRdata;
            if (cfgCycle.req) begin
                waitN <= slow ? 7 : 1;
            end else if (waitN == 1) begin
                cfgDone <= 1'b1;
                cfgRdata <= {cfgCycle.addr[15:0], cfgCycle.addr[31:16]};
                waitN <= 0;
            end else if (waitN > 1) begin
                waitN <= waitN - 1;
            end
        end
    end
endmodule // cfg_responder

`default_nettype wire

/* verif/local_bus_strap_reset_irq_tb.sv */
/*
 * Self-checking bench of the strap, reset and interrupt block.
 * Assumes the package, the design and the configuration responder.
 */
`default_nettype none

module local_bus_strap_reset_irq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [lbr_pkg::REG_AW-1:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic local_reset_in_n = 1'b1;
    logic pci_side_reset_n = 1'b1;
    logic pciRstRegWrite = 1'b0;
    logic pciRstRegData = 1'b0;
    logic local_reset_out_n;
    logic rootBridgeStrap = 1'b1;
    logic local_width_strap = 1'b1;
    logic burst_length_strap = 1'b1;
    lbr_pkg::burst_req_t burstIn = '0;
    logic burst_acknowledge_n;
    logic [3:0] transferBeats;
    logic [7:0] laneValid;
    lbr_pkg::cfg_cycle_t cfgCycle;
    logic cfgDone;
    logic [31:0] cfgRdata;
    logic extCause = 1'b0;
    logic localIrq_n;
    logic slow = 1'b0;
    int mismatches = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'hb2ad3c3f;
    logic [31:0] d;
    logic [31:0] a32;
    logic [31:2] a;
    logic e;
    int n;

    always #12.5 ref_clk = ~ref_clk;

    local_bus_strap_reset_irq uut (.ref_clk, .nrst, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .local_reset_in_n, .pci_side_reset_n,
        .pciRstRegWrite, .pciRstRegData, .local_reset_out_n,
        .rootBridgeStrap, .local_width_strap, .burst_length_strap,
        .burstIn, .burst_acknowledge_n, .transferBeats, .laneValid,
        .cfgCycle, .cfgDone, .cfgRdata, .extCause, .localIrq_n);

    cfg_responder far (.ref_clk, .nrst, .cfgCycle, .slow, .cfgDone,
        .cfgRdata);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Burst alignment demanded by width and length straps
    function automatic logic aligned(logic [31:2] x, logic w, logic l);
        if (w) return l ? x[5:3] == 3'h0 : x[4:3] == 2'h0;
        return l ? x[4:2] == 3'h0 : x[3:2] == 2'h0;
    endfunction

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] ad, logic [31:0] v);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= ad;
        regWdata <= v;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rdchk(string what, logic [7:0] ad, logic [31:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
        chk(what, d, exp);
    endtask

    task automatic burst(logic [31:2] x);
        @(posedge ref_clk);
        burstIn <= '{req: 1'b1, addr: x};
        @(posedge ref_clk);
        burstIn.req <= 1'b0;
        #1;
    endtask

    // Called just after a reset source was let go
    task automatic wait_release(string what);
        int k;
        k = 0;
        repeat (2) @(posedge ref_clk);
        #1 chk(what, local_reset_out_n, 1'b0);
        while (local_reset_out_n !== 1'b1 && k < 12) begin
            @(posedge ref_clk);
            #1 k++;
        end
        chk(what, k, lbr_pkg::RELEASE_CYCLES - 2);
    endtask

    task automatic pulse_local();
        @(posedge ref_clk);
        local_reset_in_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk("rst out local", local_reset_out_n, 1'b0);
        @(posedge ref_clk) local_reset_in_n <= 1'b1;
        wait_release("release local");
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_release("release nrst");
        rdchk("unmapped", 8'h40, 32'h0);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            // Straps move only while the local side is held in reset
            local_reset_in_n <= 1'b0;
            rootBridgeStrap <= i[0];
            local_width_strap <= i[1];
            burst_length_strap <= i[2];
            pulse_local();
            rdchk("config", lbr_pkg::REG_CONFIG, 32'(i[2:0]) << 1);
            wr(lbr_pkg::REG_CFG_ADDR, rnd());
            chk("cfg launch", cfgCycle.req, i[0]);
            if (!i[0]) rdchk("cfg addr", lbr_pkg::REG_CFG_ADDR, 32'h0);
            for (int k = 0; k < 6; k++) begin
                d = rnd();
                a = d[31:2];
                if (k < 2) a[5:2] = 4'h0;
                if (k == 2) a[5:2] = 4'h4;
                burst(a);
                e = aligned(a, i[1], i[2]);
                chk("ack", burst_acknowledge_n, !e);
                chk("beats", transferBeats, !e ? 1 : i[2] ? 8 : 4);
                chk("lanes", laneValid, i[1] ? 8'hff : 8'hf0);
            end
        end
        $display("done straps and bursts");
        // Configuration read then write, slow far side
        wr(lbr_pkg::REG_IRQ_CLEAR, 32'h7);
        slow <= 1'b1;
        a32 = rnd();
        wr(lbr_pkg::REG_CFG_ADDR, a32);
        chk("cfg rd addr", cfgCycle.addr, a32);
        chk("cfg rd dir", cfgCycle.write, 1'b0);
        n = 0;
        d = 32'h10;
        while (d[4] && n < 20) begin
            // Slow far side: four reads still busy, the fifth idle
            rdchk("poll", lbr_pkg::REG_CONFIG,
                  n < 4 ? 32'h1e : 32'h0e);
            n++;
        end
        chk("cfg busy", d[4], 1'b0);
        rdchk("cfg data", lbr_pkg::REG_CFG_DATA, {a32[15:0], a32[31:16]});
        rdchk("status cfg", lbr_pkg::REG_IRQ_STATUS, 32'h1);
        d = rnd();
        wr(lbr_pkg::REG_CFG_DATA, d);
        chk("cfg wr", {cfgCycle.req, cfgCycle.write}, 2'b11);
        chk("cfg wr data", cfgCycle.data, d);
        chk("cfg wr addr", cfgCycle.addr, a32);
        // Let the slow write finish before the interrupt checks
        repeat (9) @(posedge ref_clk);
        rdchk("cfg wr idle", lbr_pkg::REG_CONFIG, 32'he);
        $display("done config");
        // Interrupt: enable, disable, clear, external cause
        wr(lbr_pkg::REG_IRQ_ENABLE, 32'h1);
        chk("irq on", localIrq_n, 1'b0);
        wr(lbr_pkg::REG_IRQ_ENABLE, 32'h0);
        chk("irq masked", localIrq_n, 1'b1);
        wr(lbr_pkg::REG_IRQ_ENABLE, 32'h6);
        wr(lbr_pkg::REG_IRQ_CLEAR, 32'h1);
        rdchk("status clr", lbr_pkg::REG_IRQ_STATUS, 32'h0);
        chk("irq idle", localIrq_n, 1'b1);
        @(posedge ref_clk);
        extCause <= 1'b1;
        @(posedge ref_clk);
        extCause <= 1'b0;
        #1 chk("irq ext", localIrq_n, 1'b0);
        wr(lbr_pkg::REG_IRQ_CLEAR, 32'h4);
        chk("irq cleared", localIrq_n, 1'b1);
        burst(30'h2);
        chk("irq misalign", localIrq_n, 1'b0);
        $display("done interrupt");
        // Local reset clears init bit and non-PCI registers
        wr(lbr_pkg::REG_CONFIG, 32'h1);
        rdchk("init set", lbr_pkg::REG_CONFIG, 32'hf);
        pulse_local();
        rdchk("init clr", lbr_pkg::REG_CONFIG, 32'he);
        rdchk("enable clr", lbr_pkg::REG_IRQ_ENABLE, 32'h0);
        rdchk("status clr2", lbr_pkg::REG_IRQ_STATUS, 32'h0);
        chk("irq after rst", localIrq_n, 1'b1);
        // PCI reset and software reset bit
        @(posedge ref_clk);
        pci_side_reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk("rst out pci", local_reset_out_n, 1'b0);
        @(posedge ref_clk) pci_side_reset_n <= 1'b1;
        wait_release("release pci");
        @(posedge ref_clk);
        pciRstRegWrite <= 1'b1;
        pciRstRegData <= 1'b1;
        @(posedge ref_clk);
        pciRstRegWrite <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk("rst out soft", local_reset_out_n, 1'b0);
        @(posedge ref_clk);
        pciRstRegWrite <= 1'b1;
        pciRstRegData <= 1'b0;
        @(posedge ref_clk);
        pciRstRegWrite <= 1'b0;
        wait_release("release soft");
        $display("done resets");
        final_report();
    end
endmodule // local_bus_strap_reset_irq_tb

`default_nettype wire
